// >>> hdl/rtcifu_defines.vh
// constants for the clock event flag and update block
// Summary of operation
// - overflow flag bit 7 on counter overflow
// - periodic flags in bits six down to zero
// - flags stay set after interrupt acceptance
// - write zero clears flag, one ignored
// - soft reset clears all event flags
// - external, watchdog reset leave clock registers
// - busy precedes time update, lasts 62.5 ms
// - week event when day-of-week becomes zero
// - day event when day-of-week advances
// - hour, minute, second events on advance
// - half and quarter second periodic events
// - eight sources, each with own enable
// - timing select places events in busy
// - soft reset clears all except itself and the irq enable
// - disabled event leaves its flag unchanged
`ifndef RTCIFU_DEFINES_VH
`define RTCIFU_DEFINES_VH

// timing
`define RTCIFU_CLK_KHZ 40000
`define RTCIFU_QUARTER_MS 250
`define RTCIFU_BUSY_US 62500
`define RTCIFU_QUARTER_CYC (`RTCIFU_QUARTER_MS * `RTCIFU_CLK_KHZ)
// scale the clock down first: microseconds times kilohertz would overflow a 32-bit integer
`define RTCIFU_BUSY_CYC (`RTCIFU_BUSY_US * (`RTCIFU_CLK_KHZ / 1000))
`define RTCIFU_LAST_QUARTER 2'h3
`define RTCIFU_FRC_DIV 8

// register byte offsets
`define RTCIFU_OFF_CTRL 8'h00
`define RTCIFU_OFF_ENABLE 8'h04
`define RTCIFU_OFF_FLAGS 8'h08
`define RTCIFU_OFF_STATUS 8'h0c
`define RTCIFU_OFF_SEC 8'h10
`define RTCIFU_OFF_MIN 8'h14
`define RTCIFU_OFF_HOUR 8'h18
`define RTCIFU_OFF_DOW 8'h1c
`define RTCIFU_OFF_IRQEN 8'h20

// control fields
`define RTCIFU_CTRL_RUN 7
`define RTCIFU_CTRL_SRST 4
`define RTCIFU_CTRL_INTSEL 3
`define RTCIFU_CTRL_FRC 0

// flag and enable bit positions
`define RTCIFU_BIT_OVF 7
`define RTCIFU_BIT_WEEK 6
`define RTCIFU_BIT_DAY 5
`define RTCIFU_BIT_HOUR 4
`define RTCIFU_BIT_MIN 3
`define RTCIFU_BIT_SEC 2
`define RTCIFU_BIT_HALF 1
`define RTCIFU_BIT_QUARTER 0
`define RTCIFU_NUM_FLAGS 8

// counter limits
`define RTCIFU_SEC_MAX 8'h3b
`define RTCIFU_MIN_MAX 8'h3b
`define RTCIFU_HOUR_MAX 8'h17
`define RTCIFU_DOW_MAX 8'h06
`define RTCIFU_FRC_MAX 8'hff

`endif

// >>> hdl/rtcifu_top.v
// clock event flags, update busy window and apb register slave
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/100ps
`include "rtcifu_defines.vh"

module rtcifu_top #(
    parameter QUARTER_CYC = `RTCIFU_QUARTER_CYC,
    parameter BUSY_CYC = `RTCIFU_BUSY_CYC,
    parameter FRC_DIV = `RTCIFU_FRC_DIV
) (
    // clock and reset
    input wire CORE_CLK,
    input wire RST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // interrupt request to the processor
    output reg IRQ
);

    localparam [31:0] Q_LAST = QUARTER_CYC - 1;
    localparam [31:0] B_LAST = BUSY_CYC - 1;
    localparam [31:0] F_LAST = FRC_DIV - 1;

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = hit(a, `RTCIFU_OFF_CTRL) | hit(a, `RTCIFU_OFF_ENABLE) | hit(a, `RTCIFU_OFF_FLAGS) |
                     hit(a, `RTCIFU_OFF_STATUS) | hit(a, `RTCIFU_OFF_SEC) | hit(a, `RTCIFU_OFF_MIN) |
                     hit(a, `RTCIFU_OFF_HOUR) | hit(a, `RTCIFU_OFF_DOW) | hit(a, `RTCIFU_OFF_IRQEN);
        end
    endfunction

    // clock-domain registers: no asynchronous reset, only the soft reset bit
    reg run;
    reg srst;
    reg int_sel;
    reg frc_mode;
    reg [7:0] enables;
    wire [7:0] clock_event_flags;
    reg [7:0] sec;
    reg [7:0] min;
    reg [7:0] hour;
    reg [7:0] dow;
    reg [7:0] frc;
    reg [31:0] frc_pre;
    reg [31:0] qcnt;
    reg [1:0] quarter;
    reg update_in_progress;
    reg [31:0] bcnt;
    reg [7:0] pend;
    // bus side, reset by RST
    reg clock_irq_request_enable;

    wire setup = PSEL & ~PENABLE;
    wire wr = PSEL & PENABLE & PWRITE & PREADY;
    wire wr_ctrl = wr & hit(PADDR, `RTCIFU_OFF_CTRL);
    wire wr_en = wr & hit(PADDR, `RTCIFU_OFF_ENABLE);
    wire wr_flags = wr & hit(PADDR, `RTCIFU_OFF_FLAGS);
    wire wr_sec = wr & hit(PADDR, `RTCIFU_OFF_SEC);
    wire wr_min = wr & hit(PADDR, `RTCIFU_OFF_MIN);
    wire wr_hour = wr & hit(PADDR, `RTCIFU_OFF_HOUR);
    wire wr_dow = wr & hit(PADDR, `RTCIFU_OFF_DOW);
    wire wr_irqen = wr & hit(PADDR, `RTCIFU_OFF_IRQEN);

    // event decode
    wire rtc_on = run & ~frc_mode;
    wire tick_q = rtc_on & (qcnt == Q_LAST);
    wire busy_start = tick_q & (quarter == `RTCIFU_LAST_QUARTER);
    wire busy_end = update_in_progress & (bcnt == B_LAST);
    wire frc_tick = run & frc_mode & (frc_pre == F_LAST);
    wire adv_min = (sec == `RTCIFU_SEC_MAX);
    wire adv_hour = adv_min & (min == `RTCIFU_MIN_MAX);
    wire adv_day = adv_hour & (hour == `RTCIFU_HOUR_MAX);
    wire adv_week = adv_day & (dow == `RTCIFU_DOW_MAX);

    reg [7:0] time_mask;
    reg [7:0] ev;
    reg [7:0] clr_mask;
    reg [7:0] next_flags;
    reg [31:0] next_rdata;

    always @* begin
        time_mask = 8'h00;
        time_mask[`RTCIFU_BIT_WEEK] = adv_week;
        time_mask[`RTCIFU_BIT_DAY] = adv_day;
        time_mask[`RTCIFU_BIT_HOUR] = adv_hour;
        time_mask[`RTCIFU_BIT_MIN] = adv_min;
        time_mask[`RTCIFU_BIT_SEC] = 1'b1;
        // select 0 fires as busy opens, select 1 as it closes
        if (int_sel) begin
            ev = busy_end ? pend : 8'h00;
        end else begin
            ev = busy_start ? time_mask : 8'h00;
        end
        ev[`RTCIFU_BIT_QUARTER] = tick_q;
        ev[`RTCIFU_BIT_HALF] = tick_q & quarter[0];
        ev[`RTCIFU_BIT_OVF] = frc_tick & (frc == `RTCIFU_FRC_MAX);
        clr_mask = wr_flags ? ~PWDATA[7:0] : 8'h00;
        // set wins over a clear landing in the same cycle; acceptance never clears
        next_flags = (clock_event_flags & ~clr_mask) | (ev & enables);
    end

    always @* begin
        next_rdata = 32'h0000_0000;
        case (PADDR)
            `RTCIFU_OFF_CTRL: begin
                next_rdata[`RTCIFU_CTRL_RUN] = run;
                next_rdata[`RTCIFU_CTRL_SRST] = srst;
                next_rdata[`RTCIFU_CTRL_INTSEL] = int_sel;
                next_rdata[`RTCIFU_CTRL_FRC] = frc_mode;
            end
            `RTCIFU_OFF_ENABLE: next_rdata[7:0] = enables;
            `RTCIFU_OFF_FLAGS: next_rdata[7:0] = clock_event_flags;
            `RTCIFU_OFF_STATUS: next_rdata[0] = update_in_progress;
            `RTCIFU_OFF_SEC: next_rdata[7:0] = frc_mode ? frc : sec;
            `RTCIFU_OFF_MIN: next_rdata[7:0] = min;
            `RTCIFU_OFF_HOUR: next_rdata[7:0] = hour;
            `RTCIFU_OFF_DOW: next_rdata[7:0] = dow;
            `RTCIFU_OFF_IRQEN: next_rdata[0] = clock_irq_request_enable;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // one flop per flag; no RST here, only the soft reset bit empties them
    genvar g;
    generate
        for (g = 0; g < `RTCIFU_NUM_FLAGS; g = g + 1) begin : g_flag
            reg flag_bit;
            always @(posedge CORE_CLK) begin
                if (srst) begin
                    flag_bit <= 1'b0;
                end else begin
                    flag_bit <= next_flags[g];
                end
            end
            assign clock_event_flags[g] = flag_bit;
        end
    endgenerate

    // bus interface: one access cycle, answer registered
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            IRQ <= 1'b0;
            clock_irq_request_enable <= 1'b0;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup & ~mapped(PADDR);
            if (setup & ~PWRITE) begin
                PRDATA <= next_rdata;
            end
            if (wr_irqen) begin
                clock_irq_request_enable <= PWDATA[0];
            end
            IRQ <= clock_irq_request_enable & (|clock_event_flags);
        end
    end

    // the soft reset bit itself is only ever changed by software
    always @(posedge CORE_CLK) begin
        if (wr_ctrl) begin
            srst <= PWDATA[`RTCIFU_CTRL_SRST];
        end
    end

    // RST deliberately absent: time, control and flags survive the pin and watchdog resets
    always @(posedge CORE_CLK) begin
        if (srst) begin
            run <= 1'b0;
            int_sel <= 1'b0;
            frc_mode <= 1'b0;
            enables <= 8'h00;
            sec <= 8'h00;
            min <= 8'h00;
            hour <= 8'h00;
            dow <= 8'h00;
            frc <= 8'h00;
            frc_pre <= 32'h0000_0000;
            qcnt <= 32'h0000_0000;
            quarter <= 2'h0;
            update_in_progress <= 1'b0;
            bcnt <= 32'h0000_0000;
            pend <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                run <= PWDATA[`RTCIFU_CTRL_RUN];
                int_sel <= PWDATA[`RTCIFU_CTRL_INTSEL];
                frc_mode <= PWDATA[`RTCIFU_CTRL_FRC];
            end
            if (wr_en) begin
                enables <= PWDATA[7:0];
            end
            // quarter-second timebase
            if (rtc_on) begin
                qcnt <= tick_q ? 32'h0000_0000 : qcnt + 32'h0000_0001;
                if (tick_q) begin
                    quarter <= quarter + 2'h1;
                end
            end
            // busy window: raised first, time advances when it closes
            if (busy_start) begin
                update_in_progress <= 1'b1;
                bcnt <= 32'h0000_0000;
                pend <= time_mask;
            end else if (busy_end) begin
                update_in_progress <= 1'b0;
            end else if (update_in_progress) begin
                bcnt <= bcnt + 32'h0000_0001;
            end
            if (busy_end) begin
                sec <= adv_min ? 8'h00 : sec + 8'h01;
                if (adv_min) begin
                    min <= adv_hour ? 8'h00 : min + 8'h01;
                end
                if (adv_hour) begin
                    hour <= adv_day ? 8'h00 : hour + 8'h01;
                end
                if (adv_day) begin
                    dow <= adv_week ? 8'h00 : dow + 8'h01;
                end
            end
            // software writes land after any update in the same cycle
            if (wr_sec) begin
                sec <= PWDATA[7:0];
            end
            if (wr_min) begin
                min <= PWDATA[7:0];
            end
            if (wr_hour) begin
                hour <= PWDATA[7:0];
            end
            if (wr_dow) begin
                dow <= PWDATA[7:0];
            end
            // free-running counter shares the seconds address
            if (run & frc_mode) begin
                frc_pre <= frc_tick ? 32'h0000_0000 : frc_pre + 32'h0000_0001;
                if (frc_tick) begin
                    frc <= frc + 8'h01;
                end
            end
        end
    end

endmodule // rtcifu_top

// >>> sim/rtcifu_properties.sv
// assertions on the bus and irq ports of the clock event block
`timescale 1ns/100ps
module rtcifu_properties (
    // clock and reset
    input wire CORE_CLK,
    input wire RST,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    // interrupt
    input wire IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_done;
        PSEL && PENABLE && PREADY;
    endsequence
    chk_ready_next: assert property (s_setup |=> PREADY)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    chk_err_cause: assert property (PSLVERR |-> s_done)
        else $error("error outside access");
    chk_err_unmapped: assert property (s_done ##0 (PADDR > 8'h20) |-> PSLVERR)
        else $error("unmapped not refused");
    chk_flags_mapped: assert property (s_done ##0 (PADDR == 8'h08) |-> !PSLVERR)
        else $error("flag access refused");
    chk_rd_upper: assert property (s_done ##0 !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_rd_zero: assert property (s_done ##0 (PSLVERR && !PWRITE) |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    chk_rd_hold: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
        else $error("read data moved");
    chk_irq_off: assert property (s_done ##0 (PWRITE && PADDR == 8'h20 && !PWDATA[0]) |=> ##1 !IRQ)
        else $error("irq stayed after disable");
endmodule // rtcifu_properties

bind rtcifu_top rtcifu_properties u_props (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ));

// >>> sim/rtcifu_top_tb.sv
// self-checking bench for the clock event block
`timescale 1ns/100ps
module rtcifu_top_tb;
    logic core_clk, rst, psel, penable, pwrite, irq, pready, pslverr;
    logic [7:0] paddr, en;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] q[$];
    logic [15:0] nt;
    int failures, n_compared, cyc, seed, i;
    // short counts keep the run small
    rtcifu_top #(.QUARTER_CYC(40), .BUSY_CYC(10), .FRC_DIV(2)) uut (.CORE_CLK(core_clk), .RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
    task tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // a read note is {mask, expected} for the low byte; upper bytes must read 0
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [15:0] note);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q.push_back(note);
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_busy(input logic b);
        int k;
        k = 0;
        do begin
            apb(1'b0, 8'h0c, 32'h0, 16'h0);
            k++;
        end while (rd[0] !== b && k < 300);
    endtask
    // run until one update window has closed, then stop and read the flags
    task run_one(input logic [7:0] ctrl, input logic [7:0] ena, input logic [7:0] expf);
        apb(1'b1, 8'h04, {24'h0, ena}, 16'h0);
        apb(1'b1, 8'h08, 32'h0, 16'h0);
        apb(1'b1, 8'h00, {24'h0, ctrl}, 16'h0);
        wait_busy(1'b1);
        apb(1'b0, 8'h08, 32'h0, {8'h04, 5'h0, ~ctrl[3] & ena[2], 2'h0});
        wait_busy(1'b0);
        apb(1'b1, 8'h00, 32'h0, 16'h0);
        apb(1'b0, 8'h08, 32'h0, {8'hff, expf});
    endtask
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) begin
            nt = q.pop_front();
            chk("prdata", {24'h0, nt[7:0]}, prdata & {24'hffffff, nt[15:8]});
        end
    end
    // every aligned offset above the irq enable word is unmapped
    always @(posedge core_clk) begin
        if (psel && penable && pready) begin
            chk("pslverr", {31'h0, paddr > 8'h20}, {31'h0, pslverr});
        end
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 10000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        seed = 95053;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        // clock registers stay unknown until the soft reset bit is pulsed
        apb(1'b1, 8'h00, 32'h10, 16'h0);
        apb(1'b0, 8'h08, 32'h0, 16'hff00);
        apb(1'b1, 8'h00, 32'h0, 16'h0);
        apb(1'b1, 8'h20, 32'h1, 16'h0);
        run_one(8'h80, 8'hff, 8'h07);
        apb(1'b0, 8'h10, 32'h0, 16'hff01);
        apb(1'b1, 8'h10, 32'h3b, 16'h0);
        apb(1'b1, 8'h14, 32'h3b, 16'h0);
        apb(1'b1, 8'h18, 32'h17, 16'h0);
        apb(1'b1, 8'h1c, 32'h06, 16'h0);
        run_one(8'h88, 8'hff, 8'h7f);
        // the four time registers twice over; every read must be zero after the wrap
        for (i = 0; i < 8; i++) begin
            apb(1'b0, 8'h10 + 8'(4 * (i % 4)), 32'h0, 16'hff00);
        end
        apb(1'b1, 8'h08, 32'hff, 16'h0);
        apb(1'b0, 8'h08, 32'h0, 16'hff7f);
        apb(1'b1, 8'h08, 32'h7e, 16'h0);
        apb(1'b0, 8'h08, 32'h0, 16'hff7e);
        @(negedge core_clk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, 8'h20, 32'h0, 16'h0);
        repeat (2) @(negedge core_clk);
        chk("irq", 32'h0, {31'h0, irq});
        for (i = 0; i < 3; i++) begin
            en = 8'($random(seed));
            if (i == 0) en = en & 8'hf8;
            run_one({4'h8, i[0], 3'h0}, en, en & 8'h07);
        end
        // free-run mode: only the overflow source can fire
        apb(1'b1, 8'h04, 32'h80, 16'h0);
        apb(1'b1, 8'h08, 32'h0, 16'h0);
        apb(1'b1, 8'h00, 32'h81, 16'h0);
        repeat (600) @(posedge core_clk);
        apb(1'b1, 8'h00, 32'h0, 16'h0);
        apb(1'b0, 8'h08, 32'h0, 16'hff80);
        apb(1'b1, 8'h20, 32'h1, 16'h0);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, 8'h08, 32'h0, 16'hff80);
        apb(1'b0, 8'h04, 32'h0, 16'hff80);
        apb(1'b0, 8'h20, 32'h0, 16'hff00);
        apb(1'b1, 8'h24, 32'hff, 16'h0);
        apb(1'b0, 8'h24, 32'h0, 16'hff00);
        // let the watchers compare the last access before closing
        @(posedge core_clk);
        tally_and_finish;
    end
endmodule // rtcifu_top_tb
